// ==== src/isrb_pkg.sv ====
package isrb_pkg;
	localparam logic [7:0] CLA_ISO = 8'h00;
	localparam logic [7:0] INS_SELECT = 8'ha4;
	localparam logic [7:0] INS_READ = 8'hb0;
	localparam logic [7:0] SEL_BY_ID = 8'h00;
	localparam logic [7:0] SEL_CHILD = 8'h01;
	localparam logic [7:0] SEL_EF = 8'h02;
	localparam logic [7:0] SEL_PARENT = 8'h03;
	localparam logic [7:0] SEL_BY_NAME = 8'h04;
	localparam logic [7:0] P2_FCI = 8'h00;
	localparam logic [7:0] P2_NO_FCI = 8'h0c;
	localparam logic [7:0] LC_NONE = 8'h00;
	localparam logic [7:0] LC_FID = 8'h02;
	localparam logic [7:0] LC_MAX = 8'h10;
	localparam logic [15:0] MF_FID = 16'h3f00;
	localparam logic [4:0] SFI_CURRENT = 5'h00;
	localparam logic [4:0] SFI_RFU = 5'h1f;
	localparam logic [1:0] P1_RFU_OK = 2'h0;
	localparam logic [3:0] RIGHT_FREE = 4'he;
	localparam logic [3:0] RIGHT_NEVER = 4'hf;
	localparam logic [8:0] MAX_RSP = 9'h100;
	localparam logic [15:0] SW_OK = 16'h9000;
	localparam logic [15:0] SW_MEM_FAIL = 16'h6581;
	localparam logic [15:0] SW_LENGTH = 16'h6700;
	localparam logic [15:0] SW_SECURITY = 16'h6982;
	localparam logic [15:0] SW_NOT_ALLOWED = 16'h6985;
	localparam logic [15:0] SW_NOT_FOUND = 16'h6a82;
	localparam logic [15:0] SW_BAD_P1P2 = 16'h6a86;
	localparam logic [15:0] SW_LC_VS_P1P2 = 16'h6a87;
	localparam logic [15:0] SW_BAD_INS = 16'h6d00;
	localparam logic [15:0] SW_BAD_CLA = 16'h6e00;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_HDR = 8'h04;
	localparam logic [7:0] REG_LEN = 8'h08;
	localparam logic [7:0] REG_DATA0 = 8'h10;
	localparam logic [7:0] REG_DATA1 = 8'h14;
	localparam logic [7:0] REG_DATA2 = 8'h18;
	localparam logic [7:0] REG_DATA3 = 8'h1c;
	localparam logic [7:0] REG_STATUS = 8'h20;
	localparam logic [7:0] REG_IRQ_ST = 8'h24;
	localparam logic [7:0] REG_IRQ_MASK = 8'h28;
	localparam int CTRL_GO_BIT = 0;
	localparam int LEN_LE_LSB = 8;
	localparam int LEN_LE_PRES_BIT = 16;
	localparam int STAT_BUSY_BIT = 31;
	localparam int STAT_FILE_LSB = 20;
	localparam int STAT_LVL_LSB = 16;
	localparam int IRQ_DONE_BIT = 0;
	localparam int IRQ_ERR_BIT = 1;

	typedef enum logic [1:0] {
		LVL_NONE = 2'b00,
		LVL_MF = 2'b01,
		LVL_APP = 2'b10,
		LVL_FILE = 2'b11
	} isrb_level_e;

	typedef enum logic [1:0] {
		LK_FID = 2'b00,
		LK_NAME = 2'b01,
		LK_SFI = 2'b10
	} isrb_look_e;

	typedef struct packed {
		logic [7:0] cla;
		logic [7:0] ins;
		logic [7:0] p1;
		logic [7:0] p2;
	} isrb_hdr_s;

	typedef struct packed {
		isrb_look_e mode;
		logic [15:0] fid;
		logic [4:0] sfi;
		logic [3:0][31:0] name;
		logic [7:0] name_len;
	} isrb_lookup_s;

	typedef struct packed {
		logic exists;
		logic std;
		logic tmac;
		logic sdm_en;
		logic [3:0] rd;
		logic [3:0] rw;
		logic [3:0] sdm_rd;
		logic ctr_ovf;
		logic [23:0] ctr;
		logic [23:0] ctr_lim;
		logic [15:0] size;
	} isrb_attr_s;

	typedef struct packed {
		logic [7:0] data;
		logic last;
	} isrb_rsp_s;
endpackage : isrb_pkg

// ==== src/isrb_handler.sv ====
// What this block does
// R1: Select data length 0..16; empty selects master.
// R2: Select mode 04h looks up directory name.
// R3: Missing target gives 6A82h, selection kept.
// R4: Length 6700h, P1/P2 6A86h, class 6E00h.
// R5: Chained or multi-pass ongoing gives 6985h.
// R6: Length disagreeing with select mode gives 6A87h.
// R7: Read is class 00h, B0h, plain only.
// R8: No free right and unique right Fh: 6982h.
// R9: P1 bit7 set: RFU zero, SFI, byte offset.
// R10: SFI 00h is current file; 1Fh reserved.
// R11: P1 bit7 clear: 15-bit offset from P1,P2.
// R12: Le 00h reads rest of file, max 256.
// R13: Unique read counter overflow gives 6982h.
// R14: Counter at or over limit gives 6982h.
// R15: Authenticated session active gives 6982h.
// R16: No file, non-standard, transaction MAC: 6985h.
// R17: Instruction A4h selects master, application or file.
// R18: Selection never returns control information data.
// R19: Data then status word; 9000h, 6A82h, 6581h.
`timescale 1ns/1ps
`default_nettype none
module isrb_handler (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic chain_busy_i,
	input wire logic aes_session_active_i,
	input wire logic leakage_resilient_session_active_i,
	output logic lk_req_o,
	output isrb_pkg::isrb_lookup_s lk_key_o,
	input wire logic lk_done_i,
	input wire logic lk_found_i,
	input wire isrb_pkg::isrb_level_e lk_level_i,
	input wire logic [4:0] lk_file_i,
	output logic [4:0] attr_file_o,
	input wire isrb_pkg::isrb_attr_s attr_i,
	output logic mem_rd_o,
	output logic [14:0] mem_addr_o,
	input wire logic mem_ack_i,
	input wire logic mem_err_i,
	input wire logic [7:0] mem_data_i,
	output logic rsp_valid_o,
	input wire logic rsp_ready_i,
	output isrb_pkg::isrb_rsp_s rsp_o,
	output logic irq_o
);
	import isrb_pkg::*;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_SEL_LOOK = 3'b001,
		ST_RD_LOOK = 3'b010,
		ST_RD_CHECK = 3'b011,
		ST_RD_MEM = 3'b100,
		ST_RD_SEND = 3'b101,
		ST_SW_HI = 3'b110,
		ST_SW_LO = 3'b111
	} isrb_state_e;

	typedef struct packed {
		isrb_state_e st;
		isrb_hdr_s hdr;
		logic [7:0] lc;
		logic [7:0] le;
		logic le_pres;
		logic [3:0][31:0] data;
		logic [15:0] sw;
		isrb_level_e lvl;
		logic [4:0] sel_file;
		logic [4:0] tgt;
		logic [14:0] off;
		logic [8:0] cnt;
		logic [7:0] rsp_byte;
		logic [1:0] irq_st;
		logic [1:0] irq_mask;
		logic irq;
		logic ack;
		logic [31:0] rdat;
	} isrb_core_s;

	isrb_core_s q;
	isrb_core_s d;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wr,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
		begin
			if (sel[i])
			begin
				r[8*i +: 8] = wr[8*i +: 8];
			end
		end
		return r;
	endfunction : merge

	function automatic logic is_free(input logic [3:0] right);
		return right == RIGHT_FREE;
	endfunction : is_free

	// A select data length fits its mode only in these combinations.
	function automatic logic sel_len_ok(input logic [7:0] p1, input logic [7:0] lc);
		case (p1)
			SEL_BY_ID: return lc == LC_NONE || lc == LC_FID;
			SEL_CHILD, SEL_EF: return lc == LC_FID;
			SEL_PARENT: return lc == LC_NONE;
			default: return lc != LC_NONE;
		endcase
	endfunction : sel_len_ok

	logic wr;
	logic go;
	logic busy;
	logic fin;
	logic [15:0] fin_sw;
	logic [1:0] irq_set;
	logic [1:0] irq_clr;
	logic [15:0] fid;
	logic [15:0] avail;

	assign busy = q.st != ST_IDLE;
	assign fid = {q.data[0][7:0], q.data[0][15:8]};
	assign avail = attr_i.size - {1'b0, q.off};

	always_comb
	begin
		d = q;
		go = 1'b0;
		fin = 1'b0;
		fin_sw = SW_OK;
		irq_set = 2'b00;
		irq_clr = 2'b00;
		wr = wb_cyc_i && wb_stb_i && wb_we_i && !q.ack;
		d.ack = wb_cyc_i && wb_stb_i && !q.ack;
		// Command registers are frozen while a command runs, so a late write cannot
		// change the parameters that the checks are still looking at.
		if (wr)
		begin
			case (wb_adr_i)
				REG_CTRL: go = wb_sel_i[0] && wb_dat_i[CTRL_GO_BIT];
				REG_HDR: if (!busy) d.hdr = merge(q.hdr, wb_dat_i, wb_sel_i);
				REG_LEN:
				begin
					if (!busy && wb_sel_i[0])
						d.lc = wb_dat_i[7:0];
					if (!busy && wb_sel_i[1])
						d.le = wb_dat_i[LEN_LE_LSB +: 8];
					if (!busy && wb_sel_i[2])
						d.le_pres = wb_dat_i[LEN_LE_PRES_BIT];
				end
				REG_DATA0: if (!busy) d.data[0] = merge(q.data[0], wb_dat_i, wb_sel_i);
				REG_DATA1: if (!busy) d.data[1] = merge(q.data[1], wb_dat_i, wb_sel_i);
				REG_DATA2: if (!busy) d.data[2] = merge(q.data[2], wb_dat_i, wb_sel_i);
				REG_DATA3: if (!busy) d.data[3] = merge(q.data[3], wb_dat_i, wb_sel_i);
				REG_IRQ_ST: if (wb_sel_i[0]) irq_clr = wb_dat_i[1:0];
				REG_IRQ_MASK: if (wb_sel_i[0]) d.irq_mask = wb_dat_i[1:0];
				default: ;
			endcase
		end
		d.rdat = '0;
		if (d.ack && !wb_we_i)
		begin
			case (wb_adr_i)
				REG_HDR: d.rdat = q.hdr;
				REG_LEN: d.rdat = {15'h0000, q.le_pres, q.le, q.lc};
				REG_DATA0: d.rdat = q.data[0];
				REG_DATA1: d.rdat = q.data[1];
				REG_DATA2: d.rdat = q.data[2];
				REG_DATA3: d.rdat = q.data[3];
				REG_STATUS:
				begin
					d.rdat[STAT_BUSY_BIT] = busy;
					d.rdat[STAT_FILE_LSB +: 5] = q.sel_file;
					d.rdat[STAT_LVL_LSB +: 2] = q.lvl;
					d.rdat[15:0] = q.sw;
				end
				REG_IRQ_ST: d.rdat[1:0] = q.irq_st;
				REG_IRQ_MASK: d.rdat[1:0] = q.irq_mask;
				default: d.rdat = '0;
			endcase
		end

		unique case (q.st)
			ST_IDLE:
			begin
				if (go)
				begin
					if (q.hdr.p1[7])
						d.off = {7'h00, q.hdr.p2}; // R9
					else
						d.off = {q.hdr.p1[6:0], q.hdr.p2}; // R11
					d.tgt = q.sel_file;
					if (q.hdr.cla != CLA_ISO)
					begin
						fin = 1'b1; // R4 R7
						fin_sw = SW_BAD_CLA;
					end
					else if (q.hdr.ins == INS_SELECT) // R17
					begin
						if (chain_busy_i)
						begin
							fin = 1'b1; // R5
							fin_sw = SW_NOT_ALLOWED;
						end
						else if (q.hdr.p1 > SEL_BY_NAME
							|| (q.hdr.p2 != P2_FCI && q.hdr.p2 != P2_NO_FCI))
						begin
							fin = 1'b1; // R4
							fin_sw = SW_BAD_P1P2;
						end
						else if (q.lc > LC_MAX)
						begin
							fin = 1'b1; // R1 R4
							fin_sw = SW_LENGTH;
						end
						else if (!sel_len_ok(q.hdr.p1, q.lc))
						begin
							fin = 1'b1; // R6
							fin_sw = SW_LC_VS_P1P2;
						end
						else if (q.lc == LC_NONE || q.hdr.p1 == SEL_PARENT
							|| (q.hdr.p1 == SEL_BY_ID && fid == MF_FID))
						begin
							// The only parent of an application is the top level.
							d.lvl = LVL_MF; // R1
							fin = 1'b1;
						end
						else
						begin
							d.st = ST_SEL_LOOK; // R2
						end
					end
					else if (q.hdr.ins == INS_READ) // R7
					begin
						if (chain_busy_i)
						begin
							fin = 1'b1; // R5
							fin_sw = SW_NOT_ALLOWED;
						end
						else if (q.lc != LC_NONE || !q.le_pres)
						begin
							fin = 1'b1; // R4
							fin_sw = SW_LENGTH;
						end
						else if (q.hdr.p1[7] && (q.hdr.p1[6:5] != P1_RFU_OK
							|| q.hdr.p1[4:0] == SFI_RFU))
						begin
							fin = 1'b1; // R9 R10
							fin_sw = SW_BAD_P1P2;
						end
						else if (q.hdr.p1[7] && q.hdr.p1[4:0] != SFI_CURRENT)
						begin
							d.st = ST_RD_LOOK; // R10
						end
						else if (q.lvl != LVL_FILE)
						begin
							fin = 1'b1; // R16
							fin_sw = SW_NOT_ALLOWED;
						end
						else
						begin
							d.st = ST_RD_CHECK; // R10
						end
					end
					else
					begin
						fin = 1'b1;
						fin_sw = SW_BAD_INS;
					end
				end
			end
			ST_SEL_LOOK:
			begin
				if (lk_done_i)
				begin
					fin = 1'b1;
					if (lk_found_i)
					begin
						d.lvl = lk_level_i;
						d.sel_file = lk_file_i;
					end
					else
					begin
						fin_sw = SW_NOT_FOUND; // R3
					end
				end
			end
			ST_RD_LOOK:
			begin
				if (lk_done_i)
				begin
					if (lk_found_i)
					begin
						// A short identifier both targets and selects the file.
						d.lvl = LVL_FILE;
						d.sel_file = lk_file_i;
						d.tgt = lk_file_i;
						d.st = ST_RD_CHECK;
					end
					else
					begin
						fin = 1'b1; // R19
						fin_sw = SW_NOT_FOUND;
					end
				end
			end
			ST_RD_CHECK:
			begin
				fin = 1'b1;
				if (!attr_i.exists)
					fin_sw = SW_NOT_FOUND; // R19
				else if (!attr_i.std || attr_i.tmac)
					fin_sw = SW_NOT_ALLOWED; // R16
				else if (aes_session_active_i || leakage_resilient_session_active_i)
					fin_sw = SW_SECURITY; // R15
				else if (!is_free(attr_i.rd) && !is_free(attr_i.rw)
					&& (!attr_i.sdm_en || attr_i.sdm_rd == RIGHT_NEVER))
					fin_sw = SW_SECURITY; // R8
				else if (attr_i.sdm_en && attr_i.ctr_ovf)
					fin_sw = SW_SECURITY; // R13
				else if (attr_i.sdm_en && attr_i.ctr >= attr_i.ctr_lim)
					fin_sw = SW_SECURITY; // R14
				else if ({1'b0, q.off} >= attr_i.size)
					fin_sw = SW_BAD_P1P2;
				else if (q.le != 8'h00 && {8'h00, q.le} > avail)
					fin_sw = SW_LENGTH;
				else
				begin
					fin = 1'b0;
					d.st = ST_RD_MEM;
					if (q.le != 8'h00)
						d.cnt = {1'b0, q.le};
					else if (avail > {7'h00, MAX_RSP})
						d.cnt = MAX_RSP; // R12
					else
						d.cnt = avail[8:0]; // R12
				end
			end
			ST_RD_MEM:
			begin
				if (mem_err_i)
				begin
					fin = 1'b1; // R19
					fin_sw = SW_MEM_FAIL;
				end
				else if (mem_ack_i)
				begin
					d.rsp_byte = mem_data_i; // R7
					d.st = ST_RD_SEND;
				end
			end
			ST_RD_SEND:
			begin
				if (rsp_ready_i)
				begin
					d.off = q.off + 15'h0001;
					d.cnt = q.cnt - 9'h001;
					if (q.cnt == 9'h001)
						fin = 1'b1; // R19
					else
						d.st = ST_RD_MEM;
				end
			end
			ST_SW_HI:
			begin
				if (rsp_ready_i)
				begin
					d.rsp_byte = q.sw[7:0];
					d.st = ST_SW_LO;
				end
			end
			ST_SW_LO:
			begin
				if (rsp_ready_i)
				begin
					d.st = ST_IDLE;
					irq_set[IRQ_DONE_BIT] = 1'b1;
					irq_set[IRQ_ERR_BIT] = q.sw != SW_OK;
				end
			end
		endcase

		// Every answer, selection included, is the status word alone after any data.
		if (fin)
		begin
			d.sw = fin_sw; // R18 R19
			d.rsp_byte = fin_sw[15:8];
			d.st = ST_SW_HI;
		end
		// A completion in the same cycle as its clear stays pending.
		d.irq_st = (q.irq_st & ~irq_clr) | irq_set;
		d.irq = |(d.irq_st & d.irq_mask);
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			q <= '0;
		else
			q <= d;
	end

	assign wb_dat_o = q.rdat;
	assign wb_ack_o = q.ack;
	assign lk_req_o = q.st == ST_SEL_LOOK || q.st == ST_RD_LOOK;
	assign lk_key_o.mode = q.st == ST_RD_LOOK ? LK_SFI
		: (q.hdr.p1 == SEL_BY_NAME ? LK_NAME : LK_FID);
	assign lk_key_o.fid = fid;
	assign lk_key_o.sfi = q.hdr.p1[4:0];
	assign lk_key_o.name = q.data;
	assign lk_key_o.name_len = q.lc;
	assign attr_file_o = q.tgt;
	assign mem_rd_o = q.st == ST_RD_MEM;
	assign mem_addr_o = q.off;
	assign rsp_valid_o = q.st == ST_RD_SEND || q.st == ST_SW_HI || q.st == ST_SW_LO;
	assign rsp_o.data = q.rsp_byte;
	assign rsp_o.last = q.st == ST_SW_LO;
	assign irq_o = q.irq;
endmodule : isrb_handler
`default_nettype wire

// ==== testbench/isrb_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module isrb_asserts (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic lk_req_o,
	input wire logic lk_done_i,
	input wire logic lk_found_i,
	input wire logic mem_rd_o,
	input wire logic mem_ack_i,
	input wire logic mem_err_i,
	input wire logic [7:0] mem_data_i,
	input wire logic rsp_valid_o,
	input wire logic rsp_ready_i,
	input wire isrb_pkg::isrb_rsp_s rsp_o
);
	import isrb_pkg::*;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_take;
		rsp_valid_o && rsp_ready_i;
	endsequence
	sequence s_byte(logic [7:0] v);
		rsp_valid_o && rsp_o.data == v;
	endsequence
	AST_LK_HOLD: assert property (lk_req_o && !lk_done_i |=> lk_req_o)
		else $error("lookup request dropped early");
	AST_LK_MISS: assert property (lk_done_i && !lk_found_i |-> ##[1:8] s_byte(8'h6a))
		else $error("missing target not answered");
	AST_MEM_HOLD: assert property (mem_rd_o && !mem_ack_i && !mem_err_i |=> mem_rd_o)
		else $error("memory read dropped early");
	AST_MEM_DATA: assert property (mem_rd_o && mem_ack_i |=>
		rsp_valid_o && rsp_o.data == $past(mem_data_i))
		else $error("read byte not passed on");
	AST_MEM_FAIL: assert property (mem_rd_o && mem_err_i |-> ##[1:8] s_byte(8'h65))
		else $error("memory failure not answered");
	AST_RSP_STAND: assert property (rsp_valid_o && !rsp_ready_i |=>
		rsp_valid_o && $stable(rsp_o))
		else $error("response byte changed while stalled");
	AST_LAST_END: assert property (s_take ##0 rsp_o.last |=> !rsp_valid_o)
		else $error("bytes after final status byte");
	AST_ONE_SIDE: assert property (!(mem_rd_o && rsp_valid_o))
		else $error("read and response overlap");
endmodule : isrb_asserts
bind isrb_handler isrb_asserts u_asserts (.clk_i, .rst_i, .lk_req_o, .lk_done_i, .lk_found_i,
	.mem_rd_o, .mem_ack_i, .mem_err_i, .mem_data_i, .rsp_valid_o, .rsp_ready_i, .rsp_o);
`default_nettype wire

// ==== testbench/isrb_far_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module isrb_far_model
	import isrb_pkg::*;
(
	input wire logic clk_i,
	input wire logic lk_req_i,
	input wire logic mem_rd_i,
	input wire logic [14:0] mem_addr_i,
	input wire logic rsp_valid_i,
	input wire isrb_rsp_s rsp_i,
	input wire logic [14:0] err_at_i,
	output logic lk_done_o,
	output logic mem_ack_o,
	output logic mem_err_o,
	output logic [7:0] mem_data_o,
	output logic rsp_ready_o
);
	logic [1:0] n = 2'h0;
	logic [7:0] d = 8'h00;
	logic [7:0] q[$];
	logic hit;
	initial
	begin
		lk_done_o = 1'b0;
		mem_ack_o = 1'b0;
		mem_err_o = 1'b0;
		rsp_ready_o = 1'b0;
	end
	assign hit = mem_rd_i && !mem_ack_o && !mem_err_o && n == 2'h1;
	// Off-ack data is inverted so a stale byte cannot pass for a fresh one.
	assign mem_data_o = mem_ack_o ? d : ~d;
	always @(posedge clk_i)
	begin
		lk_done_o <= lk_req_i && !lk_done_o && n == 2'h2;
		n <= ((lk_req_i && !lk_done_o) || (mem_rd_i && !mem_ack_o && !mem_err_o)) ? n + 2'h1 : 2'h0;
		mem_ack_o <= hit && mem_addr_i != err_at_i;
		mem_err_o <= hit && mem_addr_i == err_at_i;
		d <= mem_addr_i[7:0] ^ 8'h5a;
		rsp_ready_o <= ~rsp_ready_o;
		if (rsp_valid_i && rsp_ready_o)
			q.push_back(rsp_i.data);
	end
endmodule : isrb_far_model
`default_nettype wire

// ==== testbench/tb_iso_select_read_binary_handler.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_iso_select_read_binary_handler;
	import isrb_pkg::*;
	logic clk_i = 0, rst_i = 1, cyc = 0, we = 0, chain = 0, aes = 0, lrs = 0, found = 0;
	logic [7:0] adr = 8'h00;
	logic [31:0] dw = 32'h0, dr, st, rdat;
	logic [14:0] err_at = 15'h7fff;
	logic ack, lkr, lkd, mrd, mack, merr, rv, rr, irq;
	logic [7:0] md;
	logic [14:0] ma;
	isrb_rsp_s rsp;
	isrb_lookup_s key;
	logic [4:0] af;
	isrb_attr_s a = '0, b;
	int n_fail = 0, n_tests = 0;
	always #4 clk_i = ~clk_i;
	isrb_handler DUT (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dw), .wb_dat_o(rdat), .wb_ack_o(ack),
		.chain_busy_i(chain), .aes_session_active_i(aes),
		.leakage_resilient_session_active_i(lrs), .lk_req_o(lkr), .lk_key_o(key),
		.lk_done_i(lkd), .lk_found_i(found), .lk_level_i(LVL_FILE), .lk_file_i(5'h02),
		.attr_file_o(af), .attr_i(a), .mem_rd_o(mrd), .mem_addr_o(ma), .mem_ack_i(mack),
		.mem_err_i(merr), .mem_data_i(md), .rsp_valid_o(rv), .rsp_ready_i(rr), .rsp_o(rsp),
		.irq_o(irq));
	isrb_far_model far (.clk_i, .lk_req_i(lkr), .mem_rd_i(mrd), .mem_addr_i(ma),
		.rsp_valid_i(rv), .rsp_i(rsp), .err_at_i(err_at), .lk_done_o(lkd),
		.mem_ack_o(mack), .mem_err_o(merr), .mem_data_o(md), .rsp_ready_o(rr));
	task automatic conclude();
		$display("tests %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : conclude
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e)
		begin
			n_fail++;
			$display("wrong value at %0t: got %h, expected %h", $time, s, e);
		end
	endtask : chk
	task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d);
		int i;
		@(posedge clk_i);
		cyc <= 1'b1;
		we <= w;
		adr <= ad;
		dw <= d;
		for (i = 0; i < 20 && ack !== 1'b1; i++)
			@(posedge clk_i);
		if (ack !== 1'b1)
		begin
			n_fail++;
			conclude();
		end
		dr = rdat;
		cyc <= 1'b0;
	endtask : wb
	// Length word: Le present at bit 16, Le above Lc.
	task automatic cmd(input logic [31:0] h, l, d, input int n, o, input logic [15:0] sw);
		int i;
		far.q.delete();
		// Old completions are cleared up front so that the caller can still see this one.
		wb(1, REG_IRQ_ST, 32'h3);
		wb(1, REG_HDR, h);
		wb(1, REG_LEN, l);
		wb(1, REG_DATA0, d);
		wb(1, REG_CTRL, 32'h1);
		st = 32'h8000_0000;
		for (i = 0; i < 1000 && st[STAT_BUSY_BIT] !== 1'b0; i++)
		begin
			wb(0, REG_STATUS, 0);
			st = dr;
		end
		if (st[STAT_BUSY_BIT] !== 1'b0)
		begin
			n_fail++;
			conclude();
		end
		chk(st[15:0], sw);
		chk(far.q.size(), n + 2);
		chk({far.q[n], far.q[n + 1]}, sw);
		for (i = 0; i < n; i++)
			chk(far.q[i], 8'(o + i) ^ 8'h5a);
		wb(0, REG_IRQ_ST, 0);
		chk(dr[1:0], {sw != SW_OK, 1'b1});
		$display("test done, status %h", st[15:0]);
	endtask : cmd
	task automatic rd(input logic [15:0] p, input logic [15:0] sw);
		cmd({CLA_ISO, INS_READ, p}, 32'h10100, 0, 0, 0, sw);
	endtask : rd
	initial
	begin
		b = '0;
		b.exists = 1'b1;
		b.std = 1'b1;
		b.rd = RIGHT_FREE;
		b.rw = RIGHT_NEVER;
		b.sdm_rd = RIGHT_NEVER;
		b.size = 16'h0008;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		a <= b;
		wb(0, 8'h40, 0);
		chk(dr, 0);
		wb(1, REG_IRQ_MASK, 32'h1);
		rd(16'h0000, SW_NOT_ALLOWED);
		chk(irq, 1);
		wb(1, REG_IRQ_MASK, 32'h0);
		repeat (2) @(posedge clk_i);
		chk(irq, 0);
		cmd({CLA_ISO, INS_SELECT, 16'h000c}, 0, 0, 0, 0, SW_OK);
		chk(st[17:16], LVL_MF);
		cmd({CLA_ISO, INS_SELECT, 16'h0400}, 32'h7, 32'h0076d2, 0, 0, SW_NOT_FOUND);
		chk(st[17:16], LVL_MF);
		cmd({CLA_ISO, INS_SELECT, 16'h0300}, 0, 0, 0, 0, SW_OK);
		cmd({8'h80, INS_SELECT, 16'h000c}, 0, 0, 0, 0, SW_BAD_CLA);
		cmd({CLA_ISO, INS_SELECT, 16'h050c}, 32'h2, 0, 0, 0, SW_BAD_P1P2);
		cmd({CLA_ISO, INS_SELECT, 16'h040c}, 32'h11, 0, 0, 0, SW_LENGTH);
		cmd({CLA_ISO, INS_SELECT, 16'h010c}, 0, 0, 0, 0, SW_LC_VS_P1P2);
		found <= 1'b1;
		cmd({CLA_ISO, INS_SELECT, 16'h040c}, 32'h7, 32'h0076d2, 0, 0, SW_OK);
		chk(st[17:16], LVL_FILE);
		chk(key.mode, LK_NAME);
		chk(key.name_len, 8'h07);
		cmd({CLA_ISO, INS_READ, 16'h0001}, 32'h10200, 0, 2, 1, SW_OK);
		cmd({CLA_ISO, INS_READ, 16'h8203}, 32'h10000, 0, 5, 3, SW_OK);
		chk(af, 5'h02);
		a.size <= 16'h0104;
		cmd({CLA_ISO, INS_READ, 16'h0000}, 32'h10000, 0, 256, 0, SW_OK);
		cmd({CLA_ISO, INS_READ, 16'h0102}, 32'h10200, 0, 2, 258, SW_OK);
		cmd({CLA_ISO, INS_READ, 16'h0102}, 32'h10300, 0, 0, 0, SW_LENGTH);
		a <= b;
		cmd({CLA_ISO, 8'hca, 16'h0000}, 0, 0, 0, 0, SW_BAD_INS);
		rd(16'h9f00, SW_BAD_P1P2);
		rd(16'ha000, SW_BAD_P1P2);
		cmd({CLA_ISO, INS_READ, 16'h0000}, 0, 0, 0, 0, SW_LENGTH);
		err_at <= 15'h2;
		cmd({CLA_ISO, INS_READ, 16'h0000}, 32'h10300, 0, 2, 0, SW_MEM_FAIL);
		err_at <= 15'h7fff;
		chain <= 1'b1;
		rd(16'h0000, SW_NOT_ALLOWED);
		chain <= 1'b0;
		a.rd <= RIGHT_NEVER;
		rd(16'h0000, SW_SECURITY);
		a.sdm_en <= 1'b1;
		a.sdm_rd <= RIGHT_FREE;
		a.ctr_ovf <= 1'b1;
		rd(16'h0000, SW_SECURITY);
		a.ctr_ovf <= 1'b0;
		a.ctr <= 24'h5;
		a.ctr_lim <= 24'h5;
		rd(16'h0000, SW_SECURITY);
		a <= b;
		aes <= 1'b1;
		rd(16'h0000, SW_SECURITY);
		aes <= 1'b0;
		lrs <= 1'b1;
		rd(16'h0000, SW_SECURITY);
		lrs <= 1'b0;
		a.std <= 1'b0;
		rd(16'h0000, SW_NOT_ALLOWED);
		b.tmac = 1'b1;
		a <= b;
		rd(16'h0000, SW_NOT_ALLOWED);
		cmd({CLA_ISO, INS_SELECT, 16'h000c}, 32'h2, 32'h3f, 0, 0, SW_OK);
		chk(st[17:16], LVL_MF);
		chk(key.fid, MF_FID);
		conclude();
	end
endmodule : tb_iso_select_read_binary_handler
`default_nettype wire
